// file: oss_top.sv
/*
  Oscillator source select with the irq status and control register,
  reached over AHB-Lite.
  Assumes: one 25 MHz clock, both oscillator outputs and the irq pin
  arrive asynchronously, stop_mode comes from logic on the same clock.
*/
// Our own choices: the AHB-Lite register port and the address map.
`timescale 1ns/1ns
`include "oss_consts.svh"

// Operation
// - Reset: select low clear, high set
// - After reset internal clocks bus, external off
// - Decode two select bits per table
// - Low select zero keeps external off
// - Both bits: external runs, internal clocks
// - Irq enable readable, writable, gates requests
// - Pending flag read-only, set by requests
// - Writing clear bit drops pending flag
// - Reset sets irq enable
// - Stop halts oscillators, keeps select bits
module oss_top (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Oscillator pins and control
  input wire logic internal_lowpower_osc,
  input wire logic external_pin_osc,
  input wire logic stop_mode,
  output logic int_osc_enable,
  output logic ext_osc_enable,
  output logic clk_sel_ext,
  output logic cpu_clk,
  // External interrupt
  input wire logic ext_irq_n,
  output logic ext_irq_request
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [2:0] sync_a; // First stage, read only by sync_b
  logic [2:0] sync_b; // Safe levels: irq_n, ext osc, int osc
  logic irq_prev; // Previous irq level for edge detect

  // Two flops per pin, no logic on the first stage
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync_a <= 3'h4; // Oscs rest low while halted, irq pin idles high
      sync_b <= 3'h4; // A high osc stage here would fake a clock pulse
      irq_prev <= 1'b1;
    end else begin
      sync_a <= {ext_irq_n, external_pin_osc, internal_lowpower_osc};
      sync_b <= sync_a;
      irq_prev <= sync_b[2];
    end
  end

  logic int_s; // Synchronised internal oscillator level
  logic ext_s; // Synchronised external oscillator level
  logic irq_fall; // Falling edge of the active-low irq pin
  assign int_s = sync_b[0];
  assign ext_s = sync_b[1];
  assign irq_fall = irq_prev && !sync_b[2];

  // ****************************************
  // AHB-Lite address and data phase
  // ****************************************
  logic wr_pend; // Write data phase to the control register
  logic next_wr_pend;
  logic [31:0] next_hrdata;
  logic addr_hit; // Address phase aimed at the control register
  logic take; // Address phase accepted this edge

  // Zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign take = hsel && htrans[1] && hready;
  assign addr_hit = (haddr == `OSS_CTRL_OFFSET);

  // ****************************************
  // Control register state
  // ****************************************
  logic osc_select_low;
  logic osc_select_high;
  logic ext_irq_enable;
  logic ext_irq_pending_flag;
  logic stop_prev; // Last stop level, to catch entry
  logic next_osc_select_low;
  logic next_osc_select_high;
  logic next_ext_irq_enable;
  logic next_ext_irq_pending_flag;
  logic ext_irq_flag_clear; // Write of one to the clear bit
  logic stop_entry; // First cycle of stop

  assign ext_irq_flag_clear = wr_pend && hwdata[`OSS_BIT_FLAG_CLR];
  assign stop_entry = stop_mode && !stop_prev;

  // Next register values; read data uses them so a read right after a
  // write sees the written value
  always_comb begin
    next_osc_select_low = osc_select_low;
    next_osc_select_high = osc_select_high;
    next_ext_irq_enable = ext_irq_enable;
    next_ext_irq_pending_flag = ext_irq_pending_flag;
    if (wr_pend) begin
      next_osc_select_low = hwdata[`OSS_BIT_SEL_LOW];
      next_osc_select_high = hwdata[`OSS_BIT_SEL_HIGH];
      next_ext_irq_enable = hwdata[`OSS_BIT_IRQ_EN];
    end
    // Stop opens external interrupts so the pin can wake the part
    if (stop_entry) begin
      next_ext_irq_enable = 1'b1;
    end
    if (ext_irq_flag_clear) begin
      next_ext_irq_pending_flag = 1'b0;
    end
    // Set wins over clear so no request is lost
    if (irq_fall && ext_irq_enable) begin
      next_ext_irq_pending_flag = 1'b1;
    end
    next_wr_pend = take && hwrite && addr_hit;
    next_hrdata = 32'h0;
    if (take && !hwrite && addr_hit) begin
      // Clear bit is write-only and reads zero
      next_hrdata[`OSS_BIT_SEL_LOW] = next_osc_select_low;
      next_hrdata[`OSS_BIT_SEL_HIGH] = next_osc_select_high;
      next_hrdata[`OSS_BIT_PEND] = next_ext_irq_pending_flag;
      next_hrdata[`OSS_BIT_IRQ_EN] = next_ext_irq_enable;
    end
  end

  // Register the control state
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      osc_select_low <= `OSS_RST_SEL_LOW;
      osc_select_high <= `OSS_RST_SEL_HIGH;
      ext_irq_enable <= `OSS_RST_IRQ_EN;
      ext_irq_pending_flag <= 1'b0;
      stop_prev <= 1'b0;
      wr_pend <= 1'b0;
      hrdata <= 32'h0;
    end else begin
      osc_select_low <= next_osc_select_low;
      osc_select_high <= next_osc_select_high;
      ext_irq_enable <= next_ext_irq_enable;
      ext_irq_pending_flag <= next_ext_irq_pending_flag;
      stop_prev <= stop_mode;
      wr_pend <= next_wr_pend;
      hrdata <= next_hrdata;
    end
  end

  assign ext_irq_request = ext_irq_pending_flag && ext_irq_enable;

  // ****************************************
  // Oscillator enables and selection decode
  // ****************************************
  logic want_ext; // Only the low-only code clocks from external

  // Stop kills both oscillators but leaves the select bits alone
  assign want_ext = osc_select_low && !osc_select_high;
  assign ext_osc_enable = osc_select_low && !stop_mode;
  assign int_osc_enable = !want_ext && !stop_mode;

  // ****************************************
  // Glitch-free clock multiplexer
  // ****************************************
  oss_pkg::oss_mux_e mux_state;
  oss_pkg::oss_mux_e next_mux_state;
  logic next_cpu_clk;
  logic src_lvl; // Level of the source now in use
  logic tgt_lvl; // Level of the source software asks for

  assign src_lvl = (mux_state == oss_pkg::OSS_MUX_EXT) ? ext_s : int_s;
  assign tgt_lvl = want_ext ? ext_s : int_s;

  // Hand over only while output and new source are both low, so no runt
  // pulse appears; a source that never toggles will hold the clock low,
  // which is why software waits for settling first
  always_comb begin
    next_mux_state = mux_state;
    next_cpu_clk = src_lvl;
    case (mux_state)
      oss_pkg::OSS_MUX_INT: begin
        if (want_ext && !cpu_clk && !tgt_lvl) begin
          next_mux_state = oss_pkg::OSS_MUX_EXT;
          next_cpu_clk = 1'b0;
        end
      end
      oss_pkg::OSS_MUX_EXT: begin
        if (!want_ext && !cpu_clk && !tgt_lvl) begin
          next_mux_state = oss_pkg::OSS_MUX_INT;
          next_cpu_clk = 1'b0;
        end
      end
      default: begin
        next_mux_state = oss_pkg::OSS_MUX_INT;
        next_cpu_clk = 1'b0;
      end
    endcase
    if (stop_mode) begin
      next_cpu_clk = 1'b0;
    end
  end

  // Register the mux
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mux_state <= oss_pkg::OSS_MUX_INT;
      cpu_clk <= 1'b0;
    end else begin
      mux_state <= next_mux_state;
      cpu_clk <= next_cpu_clk;
    end
  end

  assign clk_sel_ext = (mux_state == oss_pkg::OSS_MUX_EXT);

  // ****************************************
  // Assertions
  // ****************************************
  chk_reset_select: assert property (@(posedge clock)
    $rose(rst_n) |-> !osc_select_low && osc_select_high)
    else $error("select bits wrong after reset");

  chk_reset_clock: assert property (@(posedge clock)
    $rose(rst_n) |-> !clk_sel_ext && !ext_osc_enable &&
      (int_osc_enable || stop_mode))
    else $error("internal oscillator not chosen after reset");

  chk_reset_irq_en: assert property (@(posedge clock)
    $rose(rst_n) |-> ext_irq_enable)
    else $error("irq enable not set after reset");

  chk_decode_ext: assert property (@(posedge clock) disable iff (!rst_n)
    osc_select_low && !osc_select_high && !stop_mode |->
      ext_osc_enable && !int_osc_enable)
    else $error("external-only code decoded wrongly");

  chk_ext_off_low: assert property (@(posedge clock) disable iff (!rst_n)
    !osc_select_low |-> !ext_osc_enable)
    else $error("external oscillator on with low select clear");

  chk_both_run: assert property (@(posedge clock) disable iff (!rst_n)
    osc_select_low && osc_select_high && !stop_mode |->
      ext_osc_enable && int_osc_enable && !want_ext)
    else $error("both-set code decoded wrongly");

  chk_pend_set: assert property (@(posedge clock) disable iff (!rst_n)
    irq_fall && ext_irq_enable |=> ext_irq_pending_flag)
    else $error("request lost");

  chk_pend_gate: assert property (@(posedge clock) disable iff (!rst_n)
    !ext_irq_pending_flag && !(irq_fall && ext_irq_enable) |=>
      !ext_irq_pending_flag)
    else $error("pending set without an enabled request");

  chk_pend_clear: assert property (@(posedge clock) disable iff (!rst_n)
    ext_irq_flag_clear && !(irq_fall && ext_irq_enable) |=>
      !ext_irq_pending_flag)
    else $error("clear bit did not drop pending flag");

  chk_stop_keep: assert property (@(posedge clock) disable iff (!rst_n)
    stop_mode && !wr_pend |=> $stable(osc_select_low) &&
      $stable(osc_select_high) && !cpu_clk)
    else $error("stop changed select bits or let clock run");

  chk_clk_switch: assert property (@(posedge clock) disable iff (!rst_n)
    mux_state != $past(mux_state) |-> !cpu_clk && !$past(cpu_clk))
    else $error("source switched while clock high");

  cov_to_ext: cover property (@(posedge clock) disable iff (!rst_n)
    $rose(clk_sel_ext));
  cov_back_int: cover property (@(posedge clock) disable iff (!rst_n)
    $fell(clk_sel_ext));
  cov_both_set: cover property (@(posedge clock) disable iff (!rst_n)
    osc_select_low && osc_select_high);
  cov_irq_served: cover property (@(posedge clock) disable iff (!rst_n)
    ext_irq_pending_flag ##1 !ext_irq_pending_flag);

endmodule : oss_top

// file: oss_consts.svh
/*
  Offsets, field positions, reset values and timing counts for the
  oscillator source select block.
  Assumes inclusion by bare name from the design files.
*/
`ifndef OSS_CONSTS_SVH
`define OSS_CONSTS_SVH

// ****************************************
// Register map
// ****************************************
`define OSS_CTRL_OFFSET 8'h00
`define OSS_BIT_SEL_LOW 0
`define OSS_BIT_SEL_HIGH 1
`define OSS_BIT_FLAG_CLR 2
`define OSS_BIT_PEND 3
`define OSS_BIT_IRQ_EN 7

// ****************************************
// Reset values
// ****************************************
`define OSS_RST_SEL_LOW 1'b0
`define OSS_RST_SEL_HIGH 1'b1
`define OSS_RST_IRQ_EN 1'b1

// ****************************************
// Settling counts software should honour
// ****************************************
`define OSS_EXT_SETTLE_CYC 4096
`define OSS_INT_SETTLE_CYC 16

`endif

// file: oss_pkg.sv
/*
  Types for the oscillator source select block.
  Assumes nothing of its surroundings.
*/
package oss_pkg;

  // Which oscillator currently feeds the bus clock
  typedef enum logic [0:0] {
    OSS_MUX_INT = 1'b0,
    OSS_MUX_EXT = 1'b1
  } oss_mux_e;

endpackage : oss_pkg

// file: oss_osc_model.sv
/*
  Model of the two oscillators that feed the source select block.
  Assumes the enables come from the block; a halted osc rests low.
*/
`timescale 1ns/1ns
// ****************************************
// Oscillator pair
// ****************************************
module oss_osc_model #(
  parameter int INT_HALF = 300,
  parameter int EXT_HALF = 100
) (
  // Enables from the block
  input wire logic int_osc_enable,
  input wire logic ext_osc_enable,
  // Oscillator outputs
  output logic internal_lowpower_osc,
  output logic external_pin_osc
);
  // Internal osc runs only while enabled; low when halted
  initial begin
    internal_lowpower_osc = 1'b0;
    forever begin
      wait (int_osc_enable === 1'b1);
      #(INT_HALF) internal_lowpower_osc = ~internal_lowpower_osc;
      if (int_osc_enable !== 1'b1)
        internal_lowpower_osc = 1'b0;
    end
  end
  // External resonator gives no edges while powered off
  initial begin
    external_pin_osc = 1'b0;
    forever begin
      wait (ext_osc_enable === 1'b1);
      #(EXT_HALF) external_pin_osc = ~external_pin_osc;
      if (ext_osc_enable !== 1'b1)
        external_pin_osc = 1'b0;
    end
  end
endmodule : oss_osc_model

// file: oss_top_tb.sv
/*
  Self-checking bench for the oscillator source select block.
  Assumes the oscillator model file and the design files are compiled.
*/
`timescale 1ns/1ns
`include "oss_consts.svh"
// ****************************************
// Bench top
// ****************************************
module oss_top_tb;
  logic clock, rst_n, hsel, hwrite, hready, hreadyout, hresp;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic internal_lowpower_osc, external_pin_osc, stop_mode, ext_irq_n;
  logic int_osc_enable, ext_osc_enable, clk_sel_ext, cpu_clk;
  logic ext_irq_request;
  int n_mismatch, tests_run;
  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;
  oss_top dut (.clock, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hreadyout, .hresp, .hrdata, .internal_lowpower_osc,
    .external_pin_osc, .stop_mode, .int_osc_enable, .ext_osc_enable,
    .clk_sel_ext, .cpu_clk, .ext_irq_n, .ext_irq_request);
  oss_osc_model osc (.int_osc_enable, .ext_osc_enable,
    .internal_lowpower_osc, .external_pin_osc);
  // 25 MHz clock
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // One single transfer; waits on ready, never on a fixed count
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= a;
    do @(posedge clock); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clock); while (hready !== 1'b1);
    rd = hrdata;
  endtask : xfer
  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk
  // Mux only moves at a safe low phase, so allow a bounded wait
  task wait_sel(input logic v);
    repeat (200) if (clk_sel_ext !== v) @(posedge clock);
  endtask : wait_sel
  // Bus clock must toggle when fed from the internal oscillator
  task clk_runs;
    logic hi;
    hi = 1'b0;
    repeat (60) begin
      @(posedge clock);
      hi = hi | (cpu_clk === 1'b1);
    end
    chk(32'(hi), 32'h1);
  endtask : clk_runs
  task close_out;
    $display("mismatches %0d, checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  // ****************************************
  // Scenarios
  // ****************************************
  task t_reset;
    chk(32'(int_osc_enable), 32'h1);
    chk(32'(ext_osc_enable), 32'h0);
    chk(32'(clk_sel_ext), 32'h0);
    chk(32'(cpu_clk), 32'h0);
    chk(32'(hreadyout), 32'h1);
    chk(32'(hresp), 32'h0);
    rdchk(`OSS_CTRL_OFFSET, 32'h82);
    rdchk(8'h04, 32'h0);
    xfer(1'b1, 8'h04, 32'h01);
    rdchk(`OSS_CTRL_OFFSET, 32'h82);
    clk_runs();
  endtask : t_reset
  // Reset again mid-run, with the register away from its reset value
  task t_rerst;
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    chk(32'(ext_osc_enable), 32'h0);
    chk(32'(clk_sel_ext), 32'h0);
    rdchk(`OSS_CTRL_OFFSET, 32'h82);
    clk_runs();
  endtask : t_rerst
  // Every select code, including the warm-up code 11
  task t_decode;
    for (int c = 0; c < 4; c++) begin
      xfer(1'b1, `OSS_CTRL_OFFSET, 32'h80 | c);
      repeat (2) @(posedge clock);
      chk(32'(int_osc_enable), 32'(c != 1));
      chk(32'(ext_osc_enable), 32'(c[0]));
      rdchk(`OSS_CTRL_OFFSET, 32'h80 | c);
    end
  endtask : t_decode
  // Software lingers in code 11 before the change to external; writing 11 returns the bus to internal
  task t_switch;
    xfer(1'b1, `OSS_CTRL_OFFSET, 32'h83);
    repeat (`OSS_EXT_SETTLE_CYC * 5) @(posedge clock);
    xfer(1'b1, `OSS_CTRL_OFFSET, 32'h81);
    wait_sel(1'b1);
    chk(32'(clk_sel_ext), 32'h1);
    xfer(1'b1, `OSS_CTRL_OFFSET, 32'h83);
    repeat (`OSS_INT_SETTLE_CYC * 15) @(posedge clock);
    xfer(1'b1, `OSS_CTRL_OFFSET, 32'h82);
    wait_sel(1'b0);
    chk(32'(clk_sel_ext), 32'h0);
  endtask : t_switch
  // Pin fall with enable set, clear, then fall with enable clear
  task t_irq;
    ext_irq_n <= 1'b0;
    repeat (6) @(posedge clock);
    chk(32'(ext_irq_request), 32'h1);
    rdchk(`OSS_CTRL_OFFSET, 32'h8a);
    ext_irq_n <= 1'b1;
    xfer(1'b1, `OSS_CTRL_OFFSET, 32'h8e);
    rdchk(`OSS_CTRL_OFFSET, 32'h82);
    chk(32'(ext_irq_request), 32'h0);
    xfer(1'b1, `OSS_CTRL_OFFSET, 32'h02);
    ext_irq_n <= 1'b0;
    repeat (6) @(posedge clock);
    ext_irq_n <= 1'b1;
    rdchk(`OSS_CTRL_OFFSET, 32'h02);
  endtask : t_irq
  // Stop halts both oscillators but keeps the select code
  task t_stop;
    xfer(1'b1, `OSS_CTRL_OFFSET, 32'h03);
    stop_mode <= 1'b1;
    repeat (3) @(posedge clock);
    chk(32'(int_osc_enable), 32'h0);
    chk(32'(ext_osc_enable), 32'h0);
    chk(32'(cpu_clk), 32'h0);
    stop_mode <= 1'b0;
    rdchk(`OSS_CTRL_OFFSET, 32'h83);
  endtask : t_stop
  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    n_mismatch = 0;
    tests_run = 0;
    rst_n = 1'b0;
    {hsel, hwrite, stop_mode} = 3'h0;
    ext_irq_n = 1'b1;
    haddr = 8'h00;
    htrans = 2'b00;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_decode();
    t_switch();
    t_irq();
    t_stop();
    t_rerst();
    close_out();
  end
  // Whole run needs about 21000 cycles
  initial begin
    #(40 * 40000);
    n_mismatch++;
    close_out();
  end
endmodule : oss_top_tb
